// *** include/tbd_regs.svh ***
// Register offsets, field positions, reset values and tap tables of the tick and buzzer block.
`ifndef TBD_REGS_SVH
`define TBD_REGS_SVH

// ============================================================================
// Register offsets (byte addresses on the plain register port)
// ============================================================================
`define TBD_OFS_CTRL        8'h00
`define TBD_OFS_IRQ_STATUS  8'h01
`define TBD_OFS_IRQ_MASK    8'h02
`define TBD_OFS_STATE       8'h03

// ============================================================================
// Field positions of time_base_control
// ============================================================================
`define TBD_CTRL_RATE_LSB   0
`define TBD_CTRL_RATE_MSB   2
`define TBD_CTRL_TICK_EN    3
`define TBD_CTRL_BUZZ_LSB   5
`define TBD_CTRL_BUZZ_MSB   6
`define TBD_CTRL_BUZZ_EN    7
`define TBD_CTRL_WMASK      8'hef

// ============================================================================
// Field positions of status, mask and state registers
// ============================================================================
`define TBD_IRQ_TICK        0
`define TBD_IRQ_WMASK       8'h01
`define TBD_STATE_BUZZ      0
`define TBD_STATE_TAP       1
`define TBD_STATE_SLOW      2

// ============================================================================
// Reset values
// ============================================================================
`define TBD_CTRL_RST        8'h00
`define TBD_IRQ_RST         8'h00
`define TBD_PRESC_RST       23'h000000

// ============================================================================
// Prescaler tap tables, highest code first; bit k has period 2^(k+1) counts
// ============================================================================
`define TBD_PRESC_W         23
`define TBD_TICK_FAST_TAPS  {5'h08, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0f, 5'h14, 5'h16}
`define TBD_TICK_SLOW_TAPS  {5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h0c, 5'h0e}
`define TBD_BUZZ_FAST_TAPS  {5'h09, 5'h0a, 5'h0b, 5'h0c}
`define TBD_BUZZ_SLOW_TAPS  {5'h01, 5'h02, 5'h03, 5'h04}
`define TBD_SLOW_LAST_CODE  3'h1

`endif

// *** include/tbd_pkg.sv ***
// Types shared by the tick and buzzer block.
package tbd_pkg;

  // ==========================================================================
  // Field and source types
  // ==========================================================================
  typedef logic [2:0] tbd_rate_t;
  typedef logic [1:0] tbd_buzz_rate_t;
  typedef logic [4:0] tbd_tap_t;

  // Which clock advances the prescaler.
  typedef enum logic {
    TBD_SRC_FAST,
    TBD_SRC_SLOW
  } tbd_src_t;

endpackage

// *** hdl/tbd_prescaler.sv ***
// Free-running prescaler counter advanced by a clock-enable pulse.
`timescale 1ns/1ps
`include "tbd_regs.svh"

module tbd_prescaler (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      advance,
  output logic [`TBD_PRESC_W-1:0]        count
);

  // ==========================================================================
  // Counter
  // ==========================================================================
  logic [`TBD_PRESC_W-1:0] cnt_q;
  logic [`TBD_PRESC_W-1:0] cnt_d;

  // Software never clears it, so every tap keeps its phase across enables.
  always_comb begin
    cnt_d = cnt_q;
    if (advance) begin
      cnt_d = cnt_q + `TBD_PRESC_W'(1);
    end
  end

  // Register stage.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q <= `TBD_PRESC_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;

endmodule // tbd_prescaler

// *** hdl/tbd_fall_det.sv ***
// Falling-edge detector that only reports edges after a full armed cycle.
`timescale 1ns/1ps

module tbd_fall_det (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic arm,
  input  wire logic sig,
  output logic      fall
);

  // ==========================================================================
  // Edge history
  // ==========================================================================
  logic prev_q;
  logic prev_d;
  logic armed_q;
  logic armed_d;

  // The history is only trusted once armed for a cycle, because arming and a
  // tap change can arrive in the same write and the old tap must not count.
  always_comb begin
    prev_d  = sig;
    armed_d = arm;
  end

  // Register stage.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prev_q  <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      prev_q  <= prev_d;
      armed_q <= armed_d;
    end
  end

  assign fall = arm & armed_q & prev_q & ~sig;

endmodule // tbd_fall_det

// *** hdl/tbd_top.sv ***
// Time-base tick interrupt and buzzer divider behind a plain register port.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "tbd_regs.svh"

// Functional notes
// - Tick on each falling edge of selected tap.
// - Enabling tick never clears the shared prescaler.
// - Fast source tick rates fc/2^23 down to fc/2^9.
// - Slow source tick rates; slow modes allow codes 0-1.
// - One write may set rate and enable together.
// - Buzzer pin gives square wave while enabled.
// - All four fields share one control register.
// - Buzzer rates fc/2^13..2^10 or fs/2^5..2^2.
module tbd_top (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       run_fast,
  input  wire logic       prescaler_source_select,
  input  wire logic       slow_tick,
  output logic            tick_interrupt,
  output logic            irq,
  output logic            buzzer_output_n
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  localparam logic [7:0][4:0] TICK_FAST_TAPS = `TBD_TICK_FAST_TAPS;
  localparam logic [7:0][4:0] TICK_SLOW_TAPS = `TBD_TICK_SLOW_TAPS;
  localparam logic [3:0][4:0] BUZZ_FAST_TAPS = `TBD_BUZZ_FAST_TAPS;
  localparam logic [3:0][4:0] BUZZ_SLOW_TAPS = `TBD_BUZZ_SLOW_TAPS;

  logic [7:0]                 ctrl_q;
  logic [7:0]                 ctrl_d;
  logic [7:0]                 stat_q;
  logic [7:0]                 stat_d;
  logic [7:0]                 mask_q;
  logic [7:0]                 mask_d;
  logic [7:0]                 rdata_q;
  logic [7:0]                 rdata_d;
  logic                       tick_q;
  logic                       tick_d;
  logic                       buzz_q;
  logic                       buzz_d;

  tbd_pkg::tbd_src_t          src;
  tbd_pkg::tbd_rate_t         tick_rate;
  tbd_pkg::tbd_buzz_rate_t    buzz_rate;
  tbd_pkg::tbd_tap_t          tick_idx;
  tbd_pkg::tbd_tap_t          buzz_idx;
  logic                       tick_en;
  logic                       buzz_en;
  logic                       rate_ok;
  logic                       presc_adv;
  logic [`TBD_PRESC_W-1:0]    presc;
  logic                       tick_tap;
  logic                       buzz_tap;
  logic                       tick_fall;
  logic                       wr_ctrl;
  logic                       wr_stat;
  logic                       wr_mask;

  // ==========================================================================
  // Control fields and clock source
  // ==========================================================================
  // All four fields live in the one control register.
  assign tick_rate = ctrl_q[`TBD_CTRL_RATE_MSB:`TBD_CTRL_RATE_LSB];
  assign tick_en   = ctrl_q[`TBD_CTRL_TICK_EN];
  assign buzz_rate = ctrl_q[`TBD_CTRL_BUZZ_MSB:`TBD_CTRL_BUZZ_LSB];
  assign buzz_en   = ctrl_q[`TBD_CTRL_BUZZ_EN];

  // Slow run and slow halt modes always count the low-frequency clock.
  assign src = (!run_fast || prescaler_source_select) ? tbd_pkg::TBD_SRC_SLOW
                                                      : tbd_pkg::TBD_SRC_FAST;

  // The fast source advances every cycle, the slow one on its enable pulse.
  assign presc_adv = (src == tbd_pkg::TBD_SRC_FAST) ? 1'b1 : slow_tick;

  // ==========================================================================
  // Shared prescaler
  // ==========================================================================
  // Free-running: neither enable bit touches it, so the first tick may come early.
  tbd_prescaler u_presc (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .advance (presc_adv),
    .count   (presc)
  );

  // ==========================================================================
  // Tap selection
  // ==========================================================================
  // Codes above one are undefined in slow modes; they simply produce no tick.
  always_comb begin
    if (src == tbd_pkg::TBD_SRC_FAST) begin
      tick_idx = TICK_FAST_TAPS[tick_rate];
      buzz_idx = BUZZ_FAST_TAPS[buzz_rate];
    end else begin
      tick_idx = TICK_SLOW_TAPS[tick_rate];
      buzz_idx = BUZZ_SLOW_TAPS[buzz_rate];
    end
    rate_ok  = run_fast || (tick_rate <= `TBD_SLOW_LAST_CODE);
  end

  assign tick_tap = presc[tick_idx];
  assign buzz_tap = presc[buzz_idx];

  // ==========================================================================
  // Tick edge detection
  // ==========================================================================
  // Armed only while enabled; a rate chosen in the enabling write is used at once.
  tbd_fall_det u_tick_fall (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .arm     (tick_en && rate_ok),
    .sig     (tick_tap),
    .fall    (tick_fall)
  );

  // ==========================================================================
  // Register decode
  // ==========================================================================
  assign wr_ctrl = reg_wr && (reg_addr == `TBD_OFS_CTRL);
  assign wr_stat = reg_wr && (reg_addr == `TBD_OFS_IRQ_STATUS);
  assign wr_mask = reg_wr && (reg_addr == `TBD_OFS_IRQ_MASK);

  // Control, status and mask next values; a tick beats a same-cycle clear.
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr_ctrl) begin
      ctrl_d = reg_wdata & `TBD_CTRL_WMASK;
    end
    if (wr_mask) begin
      mask_d = reg_wdata & `TBD_IRQ_WMASK;
    end
    if (wr_stat) begin
      stat_d = stat_q & ~(reg_wdata & `TBD_IRQ_WMASK);
    end
    if (tick_fall) begin
      stat_d[`TBD_IRQ_TICK] = 1'b1;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `TBD_OFS_CTRL:       rdata_d = ctrl_q;
        `TBD_OFS_IRQ_STATUS: rdata_d = stat_q;
        `TBD_OFS_IRQ_MASK:   rdata_d = mask_q;
        `TBD_OFS_STATE: begin
          rdata_d[`TBD_STATE_BUZZ] = buzz_q;
          rdata_d[`TBD_STATE_TAP]  = tick_tap;
          rdata_d[`TBD_STATE_SLOW] = (src == tbd_pkg::TBD_SRC_SLOW);
        end
        default:             rdata_d = 8'h00;
      endcase
    end
  end

  // Register stage of the software-visible state.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q  <= `TBD_CTRL_RST;
      stat_q  <= `TBD_IRQ_RST;
      mask_q  <= `TBD_IRQ_RST;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q  <= ctrl_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // The tick request is a registered pulse; the buzzer pin idles high.
  always_comb begin
    tick_d = tick_fall;
    buzz_d = buzz_en ? buzz_tap : 1'b1;
  end

  // Register stage of the pin and request outputs.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
      buzz_q <= 1'b1;
    end else begin
      tick_q <= tick_d;
      buzz_q <= buzz_d;
    end
  end

  assign tick_interrupt  = tick_q;
  assign buzzer_output_n = buzz_q;
  assign reg_rdata       = rdata_q;
  assign irq             = |(stat_q & mask_q);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  tick_sets_status_a: assert property (
    tick_fall |=> stat_q[`TBD_IRQ_TICK] && tick_interrupt)
    else $error("tick edge did not set status and pulse");

  tick_gated_a: assert property (
    tick_interrupt |-> $past(tick_en) && $past(tick_tap, 2) && !$past(tick_tap))
    else $error("tick pulse without an enabled falling edge");

  // Only a source that was already fast one cycle ago is sure to have moved the count by exactly one.
  presc_free_a: assert property (
    (src == tbd_pkg::TBD_SRC_FAST) && $past(src == tbd_pkg::TBD_SRC_FAST) && $rose(tick_en)
      |-> presc == `TBD_PRESC_W'($past(presc) + `TBD_PRESC_W'(1)))
    else $error("prescaler disturbed by enabling the tick");

  fast_rate_a: assert property (
    (src == tbd_pkg::TBD_SRC_FAST) && (tick_rate == 3'h0) |-> tick_tap == presc[22])
    else $error("fast tick rate code 0 on wrong tap");

  slow_rate_a: assert property (
    run_fast && (src == tbd_pkg::TBD_SRC_SLOW) && (tick_rate == 3'h7) |-> tick_tap == presc[0])
    else $error("slow tick rate code 7 on wrong tap");

  slow_undef_a: assert property (
    !run_fast && (tick_rate > 3'h1) |-> !tick_fall)
    else $error("tick from an undefined slow-mode code");

  joint_write_a: assert property (
    wr_ctrl && reg_wdata[3] |=> tick_en && tick_rate == $past(reg_wdata[2:0]))
    else $error("rate and enable not taken in one write");

  buzz_wave_a: assert property (
    buzz_en |=> buzzer_output_n == $past(buzz_tap))
    else $error("buzzer pin does not follow its tap");

  buzz_rate_a: assert property (
    (src == tbd_pkg::TBD_SRC_FAST) && (buzz_rate == 2'h3) |-> buzz_tap == presc[9])
    else $error("buzzer fast code 3 on wrong tap");

  ctrl_read_a: assert property (
    reg_rd && (reg_addr == `TBD_OFS_CTRL) |=> reg_rdata == $past(ctrl_q))
    else $error("control register read mismatch");

  buzz_idle_a: assert property (
    !buzz_en |=> buzzer_output_n)
    else $error("idle buzzer pin not at inactive level");

  // ==========================================================================
  // Assertions on the register port
  // ==========================================================================
  // Read data is a one-cycle answer; data left standing would look like a
  // second read to a master that samples the port every cycle.
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data stands without a read");

  ctrl_hold_a: assert property (
    !wr_ctrl |=> $stable(ctrl_q))
    else $error("control register changed without a write");

  ctrl_gap_a: assert property (
    ctrl_q[4] == 1'b0)
    else $error("unused control bit is set");

  stat_sticky_a: assert property (
    stat_q[`TBD_IRQ_TICK] && !wr_stat |=> stat_q[`TBD_IRQ_TICK])
    else $error("tick status bit lost without a clear");

  irq_masked_a: assert property (
    !mask_q[`TBD_IRQ_TICK] |-> !irq)
    else $error("interrupt raised through a closed mask");

  // ==========================================================================
  // Assertions on the prescaler and tick path
  // ==========================================================================
  presc_hold_a: assert property (
    !presc_adv |=> $stable(presc))
    else $error("prescaler moved without an advance pulse");

  // A tap stays high for at least one advance, so two ticks are never adjacent.
  tick_pulse_a: assert property (
    tick_interrupt |=> !tick_interrupt)
    else $error("tick pulse longer than one cycle");

  tick_first_a: assert property (
    $rose(tick_en) |-> !tick_fall)
    else $error("tick taken in the first enabled cycle");

  tick_off_a: assert property (
    !tick_en |=> !tick_interrupt)
    else $error("tick pulse while the tick is disabled");

  fast_rate7_a: assert property (
    (src == tbd_pkg::TBD_SRC_FAST) && (tick_rate == 3'h7) |-> tick_tap == presc[8])
    else $error("fast tick rate code 7 on wrong tap");

  // ==========================================================================
  // Assertions on the buzzer taps
  // ==========================================================================
  buzz_fast_rate_a: assert property (
    (src == tbd_pkg::TBD_SRC_FAST) && (buzz_rate == 2'h0) |-> buzz_tap == presc[12])
    else $error("buzzer fast code 0 on wrong tap");

  buzz_slow_rate_a: assert property (
    (src == tbd_pkg::TBD_SRC_SLOW) && (buzz_rate == 2'h0) |-> buzz_tap == presc[4])
    else $error("buzzer slow code 0 on wrong tap");

endmodule // tbd_top

// *** sim/tbd_buzzer_model.sv ***
// Behavioural piezo buzzer that measures the high and low runs of the buzzer pin.
`timescale 1ns/1ps

// ============================================================================
// Buzzer model
// ============================================================================
module tbd_buzzer_model (
  input  wire logic sys_clk,
  input  wire logic pin_n,
  output int        hi_len,
  output int        lo_len
);
  int   run;
  logic last;

  // Start as if the pin had idled high, so the first low run is measured whole.
  initial begin
    run    = 0;
    last   = 1'b1;
    hi_len = 0;
    lo_len = 0;
  end

  // Count cycles at one level; an unknown level breaks the run and shows as a bad length.
  always @(posedge sys_clk) begin
    if (pin_n === last) begin
      run++;
    end else begin
      if (last === 1'b1) hi_len = run;
      else lo_len = run;
      run  = 1;
      last = pin_n;
    end
  end
endmodule // tbd_buzzer_model

// *** sim/testbench.sv ***
// Self-checking bench of the tick interrupt and buzzer divider block.
`timescale 1ns/1ps
`include "tbd_regs.svh"

module testbench;
  logic       sys_clk;
  logic       rst_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       run_fast;
  logic       src_sel;
  logic       slow_tick = 1'b0;
  logic       tick_interrupt;
  logic       irq;
  logic       buzzer_output_n;
  int         hi_len;
  int         lo_len;
  int         mismatches;
  int         checked;
  int         slow_cnt = 0;
  logic [7:0] rv;
  int         n;
  int         tick_exp[2][8] = '{'{23, 21, 16, 14, 13, 12, 11, 9}, '{15, 13, 8, 6, 5, 4, 3, 1}};
  int         buzz_exp[2][4] = '{'{13, 12, 11, 10}, '{5, 4, 3, 2}};

  tbd_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_fast(run_fast),
    .prescaler_source_select(src_sel), .slow_tick(slow_tick), .tick_interrupt(tick_interrupt),
    .irq(irq), .buzzer_output_n(buzzer_output_n));

  tbd_buzzer_model buzz (.sys_clk(sys_clk), .pin_n(buzzer_output_n), .hi_len(hi_len),
    .lo_len(lo_len));

  // ==========================================================================
  // Clock, slow source pulse and watchdog
  // ==========================================================================
  // One slow pulse every 4 cycles keeps slow-source periods short enough to simulate.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Slow source enable pulse.
  always @(posedge sys_clk) begin
    slow_cnt  <= (slow_cnt + 1) % 4;
    slow_tick <= (slow_cnt == 3);
  end

  // The tests need about 45k cycles; 90k means something hung.
  initial begin
    #900_000;
    mismatches++;
    complete_run();
  end

  // ==========================================================================
  // Bus and compare tasks
  // ==========================================================================
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp, input string m);
    checked++;
    if (got != exp) begin
      mismatches++;
      $display("Error at %0t: %s got %0d expected %0d", $time, m, got, exp);
    end
  endtask

  // Counts cycles until the tick pulse is seen, giving up after lim cycles.
  task automatic wait_tick(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge sys_clk);
      #1 cnt++;
    end while (tick_interrupt !== 1'b1 && cnt < lim);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic test_regs();
    chk8({7'h00, buzzer_output_n}, 8'h01, "idle pin");
    bus_rd(`TBD_OFS_CTRL, rv);
    chk8(rv, `TBD_CTRL_RST, "ctrl reset");
    bus_rd(`TBD_OFS_STATE, rv);
    chk8(rv, 8'h01, "state after reset");
    bus_rd(8'h40, rv);
    chk8(rv, 8'h00, "unmapped read");
    bus_wr(`TBD_OFS_CTRL, 8'hff);
    bus_rd(`TBD_OFS_CTRL, rv);
    chk8(rv, 8'hef, "ctrl fields");
    bus_wr(`TBD_OFS_CTRL, 8'h67);
    bus_wr(`TBD_OFS_CTRL, 8'h00);
    bus_wr(`TBD_OFS_IRQ_MASK, 8'hff);
    bus_rd(`TBD_OFS_IRQ_MASK, rv);
    chk8(rv, 8'h01, "mask bits");
    bus_wr(`TBD_OFS_IRQ_STATUS, 8'h01);
    $display("test_regs done");
  endtask

  task automatic test_tick(input int s, input int lo_code);
    int per;
    for (int c = 7; c >= lo_code; c--) begin
      per = (2 ** tick_exp[s][c]) * (s ? 4 : 1);
      bus_wr(`TBD_OFS_CTRL, {5'h01, c[2:0]});
      wait_tick(2 * per + 8, n);
      @(posedge sys_clk);
      #1 chk8({7'h00, tick_interrupt}, 8'h00, "tick one cycle");
      wait_tick(2 * per + 8, n);
      // The edge spent on the one-cycle check belongs to this period as well.
      chk_n(n + 1, per, "tick period");
      chk8({7'h00, irq}, 8'h01, "irq raised");
      bus_rd(`TBD_OFS_IRQ_STATUS, rv);
      chk8(rv, 8'h01, "status set");
      bus_wr(`TBD_OFS_IRQ_STATUS, 8'h01);
      #1 chk8({7'h00, irq}, 8'h00, "irq cleared");
      bus_wr(`TBD_OFS_CTRL, {5'h00, c[2:0]});
    end
    $display("test_tick done");
  endtask

  task automatic test_early_tick();
    bus_wr(`TBD_OFS_IRQ_MASK, 8'h00);
    bus_wr(`TBD_OFS_CTRL, 8'h0f);
    wait_tick(600, n);
    bus_wr(`TBD_OFS_CTRL, 8'h07);
    repeat (100) @(posedge sys_clk);
    bus_wr(`TBD_OFS_CTRL, 8'h0f);
    wait_tick(600, n);
    chk_n(int'(n < 420), 1, "first tick early");
    bus_rd(`TBD_OFS_IRQ_STATUS, rv);
    chk8({7'h00, irq}, 8'h00, "masked irq"); // status set but masked
    chk8(rv, 8'h01, "status masked set");
    bus_wr(`TBD_OFS_CTRL, 8'h07);
    bus_wr(`TBD_OFS_IRQ_STATUS, 8'h01);
    bus_wr(`TBD_OFS_IRQ_MASK, 8'h01);
    $display("test_early_tick done");
  endtask

  task automatic test_slow_mode();
    @(posedge sys_clk);
    run_fast <= 1'b0;
    bus_wr(`TBD_OFS_CTRL, 8'h02);
    bus_rd(`TBD_OFS_STATE, rv);
    chk8(rv & 8'h05, 8'h05, "state slow idle");
    bus_wr(`TBD_OFS_CTRL, 8'h0a);
    wait_tick(3000, n);
    chk_n(n, 3000, "no slow tick code 2");
    bus_wr(`TBD_OFS_CTRL, 8'h02);
    $display("test_slow_mode done");
  endtask

  task automatic test_buzz(input int s, input int b);
    int per;
    per = (2 ** buzz_exp[s][b]) * (s ? 4 : 1);
    bus_wr(`TBD_OFS_CTRL, {1'b0, b[1:0], 5'h00});
    bus_wr(`TBD_OFS_CTRL, {1'b1, b[1:0], 5'h00});
    repeat (3 * per) @(posedge sys_clk);
    chk_n(hi_len, per / 2, "buzz high run");
    chk_n(lo_len, per / 2, "buzz low run");
    bus_wr(`TBD_OFS_CTRL, {1'b0, b[1:0], 5'h00});
    repeat (2) @(posedge sys_clk);
    #1 chk8({7'h00, buzzer_output_n}, 8'h01, "pin idle after stop");
    $display("test_buzz done");
  endtask

  task automatic complete_run();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, src_sel} = '0;
    {mismatches, checked} = '0;
    run_fast = 1'b1;
    rst_n    = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_regs();
    test_tick(0, 4);
    test_early_tick();
    test_buzz(0, 3);
    test_buzz(0, 2);
    @(posedge sys_clk);
    src_sel <= 1'b1;
    test_tick(1, 2);
    test_buzz(1, 0);
    test_slow_mode();
    test_buzz(1, 1);
    complete_run();
  end
endmodule // testbench
